// ===== opcd_pkg.sv
// Contract
// - Opcode AE/AF bit 0 sets panel enable
// - Panel-off command enters sleep state
// - Sleep halts oscillator and voltage converter
// - Sleep tristates all row and column drivers
// - Settings and memory survive sleep entry/exit
// - Memory access stays open during sleep
// - B0-B7 loads three-bit page address
// - Page change does not move image
// - C0/C8 bit 3 picks row scan order
// - Scan direction change takes effect immediately
// - D3 parameter low six bits set offset
// - Offset wraps modulo 64
// - D5 parameter low nibble plus one divides
// - D5 parameter high nibble trims oscillator
// - Frame rate from osc, divide, clocks, mux
// - D9 low nibble sets pre-charge, zero invalid
// - D9 high nibble sets discharge, zero invalid
// - DA parameter bit 4 picks pad layout
// - Sequential splits halves, alternating splits even/odd
package opcd_pkg;
  localparam logic [7:0] OP_DISP_OFF   = 8'hAE;
  localparam logic [4:0] OP_PAGE_HI    = 5'h16;
  localparam logic [3:0] OP_SCAN_HI    = 4'hC;
  localparam logic [7:0] OP_OFFSET     = 8'hD3;
  localparam logic [7:0] OP_CLKDIV     = 8'hD5;
  localparam logic [7:0] OP_PRECHG     = 8'hD9;
  localparam logic [7:0] OP_PADCFG     = 8'hDA;
  localparam int         PAD_ALT_BIT   = 4;
  localparam int         SCAN_BIT      = 3;
  localparam logic       RST_ENABLE    = 1'h0;
  localparam logic       RST_SCAN_DOWN = 1'h0;
  localparam logic       RST_PAD_ALT   = 1'h1;
  localparam logic [2:0] RST_PAGE      = 3'h0;
  localparam logic [5:0] RST_OFFSET    = 6'h00;
  localparam logic [3:0] RST_DIV_CODE  = 4'h0;
  localparam logic [3:0] RST_OSC_TRIM  = 4'h5;
  localparam logic [3:0] RST_PRECHG    = 4'h2;
  localparam logic [3:0] RST_DISCHG    = 4'h2;
  localparam int         ROW_CLKS      = 4;
  localparam int         ROWS          = 64;
  typedef enum logic [4:0] {
    OPCD_IDLE   = 5'b00001,
    OPCD_OFFSET = 5'b00010,
    OPCD_CLKDIV = 5'b00100,
    OPCD_PRECHG = 5'b01000,
    OPCD_PADCFG = 5'b10000
  } opcd_state_e;
endpackage

// ===== opcd_cfg_if.sv
`timescale 1ns/100ps
// Parameter bytes passed from decoder to the timing generator
interface opcd_cfg_if;
  logic       run;
  logic [3:0] div_code;
  logic [3:0] osc_trim;
  logic [3:0] prechg;
  logic [3:0] dischg;
  logic       row_tick;
  logic       frame_tick;
  modport src (output run, div_code, osc_trim, prechg, dischg, input row_tick, frame_tick);
  modport gen (input run, div_code, osc_trim, prechg, dischg, output row_tick, frame_tick);
endinterface

// ===== opcd_pixclk.sv
`timescale 1ns/100ps
// Display clock and row timing; halted while asleep
module opcd_pixclk
  import opcd_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  opcd_cfg_if.gen   cfg
);
  logic [4:0] osc_cnt_r, osc_cnt_nxt;
  logic [3:0] div_cnt_r, div_cnt_nxt;
  logic [5:0] row_cnt_r, row_cnt_nxt;
  logic [5:0] line_cnt_r, line_cnt_nxt;
  logic       pix_tick;

  // Oscillator model: trim code shortens the period for higher codes
  always_comb begin
    osc_cnt_nxt  = osc_cnt_r;
    div_cnt_nxt  = div_cnt_r;
    row_cnt_nxt  = row_cnt_r;
    line_cnt_nxt = line_cnt_r;
    pix_tick     = 1'b0;
    cfg.row_tick   = 1'b0;
    cfg.frame_tick = 1'b0;
    if (cfg.run) begin
      if (osc_cnt_r >= 5'(5'h14 - {1'b0, cfg.osc_trim})) begin
        osc_cnt_nxt = 5'h00;
        if (div_cnt_r >= cfg.div_code) begin
          div_cnt_nxt = 4'h0;
          pix_tick    = 1'b1;
        end else begin
          div_cnt_nxt = div_cnt_r + 4'h1;
        end
      end else begin
        osc_cnt_nxt = osc_cnt_r + 5'h01;
      end
      // Row length is the phase widths plus fixed clocks
      if (pix_tick) begin
        if (row_cnt_r >= 6'(cfg.prechg + cfg.dischg + 6'(ROW_CLKS) - 6'h01)) begin
          row_cnt_nxt  = 6'h00;
          cfg.row_tick = 1'b1;
          line_cnt_nxt = line_cnt_r + 6'h01;
          cfg.frame_tick = (line_cnt_r == 6'(ROWS - 1));
        end else begin
          row_cnt_nxt = row_cnt_r + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      osc_cnt_r  <= 5'h00;
      div_cnt_r  <= 4'h0;
      row_cnt_r  <= 6'h00;
      line_cnt_r <= 6'h00;
    end else begin
      osc_cnt_r  <= osc_cnt_nxt;
      div_cnt_r  <= div_cnt_nxt;
      row_cnt_r  <= row_cnt_nxt;
      line_cnt_r <= line_cnt_nxt;
    end
  end

  halt_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !cfg.run |=> $stable(osc_cnt_r) && $stable(row_cnt_r))
    else $error("timing advanced while asleep");
endmodule

// ===== opcd_decoder.sv
`timescale 1ns/100ps
// Command byte decoder with panel configuration state
module opcd_decoder
  import opcd_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_cmd_wr,
  input  wire logic       i_cmd_data_select,
  input  wire logic [7:0] i_cmd_byte,
  output logic            o_panel_on,
  output logic            o_sleep,
  output logic            o_osc_run,
  output logic            o_conv_run,
  output logic            o_drv_oe,
  output logic            o_mem_access_en,
  output logic [2:0]      o_page_addr,
  output logic            o_scan_down,
  output logic [5:0]      o_row_offset,
  output logic [4:0]      o_div_ratio,
  output logic [3:0]      o_osc_trim,
  output logic [3:0]      o_prechg_clks,
  output logic [3:0]      o_dischg_clks,
  output logic            o_pad_alt,
  output logic            o_row_tick,
  output logic            o_frame_tick,
  output logic            o_param_err
);
  opcd_cfg_if  cfg ();
  opcd_state_e state_r, state_nxt;
  logic        enable_r, enable_nxt;
  logic        sleep_r, sleep_nxt;
  logic [4:0]  ratio_r, ratio_nxt;
  logic [2:0]  page_r, page_nxt;
  logic        scan_r, scan_nxt;
  logic [5:0]  offset_r, offset_nxt;
  logic [3:0]  div_r, div_nxt;
  logic [3:0]  trim_r, trim_nxt;
  logic [3:0]  pre_r, pre_nxt;
  logic [3:0]  dis_r, dis_nxt;
  logic        pad_r, pad_nxt;
  logic        err_r, err_nxt;
  logic        row_tick_r;
  logic        frame_tick_r;
  logic        cmd_take;

  assign cmd_take = i_cmd_wr && !i_cmd_data_select;

  // Decode: a pending two-byte opcode claims the next command byte
  always_comb begin
    state_nxt  = state_r;
    enable_nxt = enable_r;
    page_nxt   = page_r;
    scan_nxt   = scan_r;
    offset_nxt = offset_r;
    div_nxt    = div_r;
    trim_nxt   = trim_r;
    pre_nxt    = pre_r;
    dis_nxt    = dis_r;
    pad_nxt    = pad_r;
    err_nxt    = 1'b0;
    if (cmd_take) begin
      case (state_r)
        OPCD_OFFSET: begin
          offset_nxt = i_cmd_byte[5:0];
          state_nxt  = OPCD_IDLE;
        end
        OPCD_CLKDIV: begin
          div_nxt   = i_cmd_byte[3:0];
          trim_nxt  = i_cmd_byte[7:4];
          state_nxt = OPCD_IDLE;
        end
        OPCD_PRECHG: begin
          // Zero is invalid; keep the previous period rather than stall
          if (i_cmd_byte[3:0] != 4'h0) begin
            pre_nxt = i_cmd_byte[3:0];
          end
          if (i_cmd_byte[7:4] != 4'h0) begin
            dis_nxt = i_cmd_byte[7:4];
          end
          err_nxt   = (i_cmd_byte[3:0] == 4'h0) || (i_cmd_byte[7:4] == 4'h0);
          state_nxt = OPCD_IDLE;
        end
        OPCD_PADCFG: begin
          pad_nxt   = i_cmd_byte[PAD_ALT_BIT];
          state_nxt = OPCD_IDLE;
        end
        OPCD_IDLE: begin
          // Undefined codes fall through untouched; host must not send them
          if (i_cmd_byte[7:1] == OP_DISP_OFF[7:1]) begin
            enable_nxt = i_cmd_byte[0];
          end else if (i_cmd_byte[7:3] == OP_PAGE_HI) begin
            page_nxt = i_cmd_byte[2:0];
          end else if (i_cmd_byte[7:4] == OP_SCAN_HI) begin
            scan_nxt = i_cmd_byte[SCAN_BIT];
          end else if (i_cmd_byte == OP_OFFSET) begin
            state_nxt = OPCD_OFFSET;
          end else if (i_cmd_byte == OP_CLKDIV) begin
            state_nxt = OPCD_CLKDIV;
          end else if (i_cmd_byte == OP_PRECHG) begin
            state_nxt = OPCD_PRECHG;
          end else if (i_cmd_byte == OP_PADCFG) begin
            state_nxt = OPCD_PADCFG;
          end
        end
        default: state_nxt = OPCD_IDLE;
      endcase
    end
    // Derived outputs are registered too, so no output has logic after its flop
    sleep_nxt = !enable_nxt;
    ratio_nxt = {1'b0, div_nxt} + 5'h01;
  end

  // Settings registers; only reset clears them, never sleep
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r  <= OPCD_IDLE;
      enable_r <= RST_ENABLE;
      sleep_r  <= !RST_ENABLE;
      ratio_r  <= {1'b0, RST_DIV_CODE} + 5'h01;
      page_r   <= RST_PAGE;
      scan_r   <= RST_SCAN_DOWN;
      offset_r <= RST_OFFSET;
      div_r    <= RST_DIV_CODE;
      trim_r   <= RST_OSC_TRIM;
      pre_r    <= RST_PRECHG;
      dis_r    <= RST_DISCHG;
      pad_r    <= RST_PAD_ALT;
      err_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      enable_r <= enable_nxt;
      sleep_r  <= sleep_nxt;
      ratio_r  <= ratio_nxt;
      page_r   <= page_nxt;
      scan_r   <= scan_nxt;
      offset_r <= offset_nxt;
      div_r    <= div_nxt;
      trim_r   <= trim_nxt;
      pre_r    <= pre_nxt;
      dis_r    <= dis_nxt;
      pad_r    <= pad_nxt;
      err_r    <= err_nxt;
    end
  end

  // Timing generator runs only while the panel is on
  assign cfg.run      = enable_r;
  assign cfg.div_code = div_r;
  assign cfg.osc_trim = trim_r;
  assign cfg.prechg   = pre_r;
  assign cfg.dischg   = dis_r;

  opcd_pixclk u_pixclk (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .cfg       (cfg.gen)
  );

  // Register the tick strobes so outputs come from flops
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      row_tick_r   <= 1'b0;
      frame_tick_r <= 1'b0;
    end else begin
      row_tick_r   <= cfg.row_tick;
      frame_tick_r <= cfg.frame_tick;
    end
  end

  // Status and configuration outputs straight from registers; memory access enable tied high
  assign o_panel_on      = enable_r;
  assign o_sleep         = sleep_r;
  assign o_osc_run       = enable_r;
  assign o_conv_run      = enable_r;
  assign o_drv_oe        = enable_r;
  assign o_mem_access_en = 1'b1;
  assign o_page_addr     = page_r;
  assign o_scan_down     = scan_r;
  assign o_row_offset    = offset_r;
  assign o_div_ratio     = ratio_r;
  assign o_osc_trim      = trim_r;
  assign o_prechg_clks   = pre_r;
  assign o_dischg_clks   = dis_r;
  assign o_pad_alt       = pad_r;
  assign o_row_tick      = row_tick_r;
  assign o_frame_tick    = frame_tick_r;
  assign o_param_err     = err_r;

  panel_cmd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmd_take && state_r == OPCD_IDLE && i_cmd_byte[7:1] == 7'h57)
    |=> o_panel_on == $past(i_cmd_byte[0]))
    else $error("panel enable did not follow command");
  sleep_drv_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_sleep |-> !o_drv_oe && !o_osc_run && !o_conv_run)
    else $error("drivers active in sleep");
  page_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmd_take && state_r == OPCD_IDLE && i_cmd_byte[7:3] == 5'h16)
    |=> o_page_addr == $past(i_cmd_byte[2:0]))
    else $error("page address not loaded");
  scan_dir_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmd_take && state_r == OPCD_IDLE && i_cmd_byte[7:4] == 4'hC)
    |=> o_scan_down == $past(i_cmd_byte[3]))
    else $error("scan direction late");
  offset_arm_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmd_take && state_r == OPCD_IDLE && i_cmd_byte == 8'hD3)
    |=> state_r == OPCD_OFFSET)
    else $error("offset opcode not armed");
  offset_par_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmd_take && state_r == OPCD_OFFSET)
    |=> o_row_offset == $past(i_cmd_byte[5:0]))
    else $error("offset parameter not taken");
  param_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmd_take && state_r != OPCD_IDLE)
    |=> state_r == OPCD_IDLE && $stable(o_panel_on))
    else $error("parameter byte decoded as command");
  keep_cfg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_sleep) |-> $stable(o_row_offset) && $stable(o_prechg_clks))
    else $error("settings lost on sleep");
  prechg_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_prechg_clks != 4'h0 && o_dischg_clks != 4'h0)
    else $error("zero phase period stored");
  div_ratio_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (cmd_take && state_r == OPCD_CLKDIV)
    |=> o_div_ratio == 5'($past(i_cmd_byte[3:0])) + 5'h01
        && o_osc_trim == $past(i_cmd_byte[7:4]))
    else $error("clock parameter wrong");
endmodule

// ===== opcd_host.sv
`timescale 1ns/100ps
// Host port model; changes its lines on the falling edge only
module opcd_host (
  input  wire logic       i_ref_clk,
  output logic            o_cmd_wr,
  output logic            o_cmd_data_select,
  output logic [7:0]      o_cmd_byte
);
  // Quiet bus at time zero
  initial begin
    o_cmd_wr          = 1'b0;
    o_cmd_data_select = 1'b1;
    o_cmd_byte        = 8'h5A;
  end

  // Strobe stays up so bytes can go back to back; callers pass defined codes only
  task automatic put(input logic ds, input logic [7:0] b);
    @(negedge i_ref_clk);
    o_cmd_wr          = 1'b1;
    o_cmd_data_select = ds;
    o_cmd_byte        = b;
  endtask

  // Released bus shows the inverse so a stale byte never looks valid
  task automatic idle();
    @(negedge i_ref_clk);
    o_cmd_wr   = 1'b0;
    o_cmd_byte = ~o_cmd_byte;
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the command decoder
module tb_top
  import opcd_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        wr, ds, pon, slp, osc, conv, oe, mem, scan, padq, rtk, ftk, perr;
  logic [7:0]  cbyte, b;
  logic [2:0]  page;
  logic [5:0]  offs;
  logic [4:0]  divr;
  logic [3:0]  trim, prec, disc;
  logic [15:0] lf = 16'h97E5;
  logic [7:0]  ops [4] = '{8'hD3, 8'hD5, 8'hD9, 8'hDA};
  logic [15:0] pairs [7] = '{16'hD3AE, 16'hD370, 16'hD900, 16'hD930, 16'hD9D9, 16'hD50F, 16'hDA02};
  int          fails = 0;
  int          checked = 0;
  int          on, pg, scn, ofs, dv, trm, pre, dis, pad, err, pend, n;

  // 125 MHz reference clock
  always #4 ref_clk = ~ref_clk;

  opcd_host host (.i_ref_clk(ref_clk), .o_cmd_wr(wr), .o_cmd_data_select(ds), .o_cmd_byte(cbyte));

  opcd_decoder uut (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_cmd_wr(wr), .i_cmd_data_select(ds),
    .i_cmd_byte(cbyte), .o_panel_on(pon), .o_sleep(slp), .o_osc_run(osc), .o_conv_run(conv),
    .o_drv_oe(oe), .o_mem_access_en(mem), .o_page_addr(page), .o_scan_down(scan),
    .o_row_offset(offs), .o_div_ratio(divr), .o_osc_trim(trim), .o_prechg_clks(prec),
    .o_dischg_clks(disc), .o_pad_alt(padq), .o_row_tick(rtk), .o_frame_tick(ftk),
    .o_param_err(perr)
  );

  // Fixed-seed sequence so every run is repeatable
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  // Power-on values of the reference model
  task automatic rst_mdl();
    on = 0; pg = 0; scn = 0; ofs = 0; dv = 1; trm = 5; pre = 2; dis = 2; pad = 1;
    err = 0; pend = 0;
  endtask

  // Reference model; a pending opcode claims the next command byte
  task automatic mdl(input logic d, input logic [7:0] v);
    err = 0;
    if (d) return;
    if (pend == 'hD3) ofs = v[5:0];
    else if (pend == 'hD5) begin dv = v[3:0] + 1; trm = v[7:4]; end
    else if (pend == 'hD9) begin
      if (v[3:0] != 0) pre = v[3:0];
      if (v[7:4] != 0) dis = v[7:4];
      err = (v[3:0] == 0) || (v[7:4] == 0);
    end
    else if (pend == 'hDA) pad = v[4];
    else if (v[7:1] == 7'h57) on = v[0];
    else if (v[7:3] == 5'h16) pg = v[2:0];
    else if (v[7:4] == 4'hC) scn = v[3];
    pend = (pend == 0 && v inside {8'hD3, 8'hD5, 8'hD9, 8'hDA}) ? v : 0;
  endtask

  task automatic cmp();
    chk("panel_on", pon, on);
    chk("sleep", slp, !on);
    chk("osc_conv", {osc, conv}, {2{on[0]}});
    chk("drv_oe", oe, on);
    chk("mem_en", mem, 1);
    chk("page", page, pg);
    chk("scan", scan, scn);
    chk("offset", offs, ofs);
    chk("div", divr, dv);
    chk("trim", trim, trm);
    chk("prechg", prec, pre);
    chk("dischg", disc, dis);
    chk("pad_alt", padq, pad);
    chk("param_err", perr, err);
  endtask

  // Every byte is checked 1 ns after the rising edge that takes it, even back to back
  task automatic snd(input logic d, input logic [7:0] v);
    host.put(d, v);
    mdl(d, v);
    @(posedge ref_clk);
    #1;
    cmp();
  endtask

  // Cycles between two successive ticks; bounded so a dead counter fails
  task automatic gap(input bit fr, output int c);
    int k;
    int t0;
    t0 = -1;
    c = 0;
    for (k = 0; k < 20000 && c == 0; k++) begin
      @(negedge ref_clk);
      if ((fr ? ftk : rtk) === 1'b1) begin
        if (t0 >= 0) c = k - t0;
        t0 = k;
      end
    end
  endtask

  task automatic complete_run();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Limit set well above the longest expected run of about 14000 cycles
  initial begin
    #320000;
    fails++;
    complete_run();
  end

  // Main sequence
  initial begin
    rst_mdl();
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    cmp();
    snd(0, 8'hAF);
    for (int i = 0; i < 8; i++) snd(0, 8'hB0 | i[7:0]);
    snd(0, 8'hC8);
    snd(0, 8'hC7);
    foreach (pairs[i]) begin
      snd(0, pairs[i][15:8]);
      snd(0, pairs[i][7:0]);
    end
    repeat (40) begin
      b = rnd();
      snd(0, ops[b[1:0]]);
      snd(0, ops[b[1:0]] == 8'hDA ? (8'h02 | (rnd() & 8'h10)) : rnd());
      snd(1, rnd());
      b = rnd();
      snd(0, {5'h16, b[2:0]});
      snd(0, {4'hC, b[7:4]});
      snd(0, {7'h57, b[3]});
    end
    snd(0, 8'hD5);
    snd(0, 8'hF1);
    snd(0, 8'hD9);
    snd(0, 8'h31);
    snd(0, 8'hAF);
    host.idle();
    gap(0, n);
    chk("row_gap", n, (21 - trm) * dv * (pre + dis + ROW_CLKS));
    gap(1, n);
    chk("frame_gap", n[15:0], (21 - trm) * dv * (pre + dis + ROW_CLKS) * ROWS);
    snd(0, 8'hAE);
    host.idle();
    n = 0;
    repeat (400) begin
      @(negedge ref_clk);
      if (rtk !== 1'b0 || ftk !== 1'b0) n++;
    end
    chk("ticks_asleep", n, 0);
    snd(0, 8'hAF);
    host.idle();
    gap(0, n);
    chk("row_gap_wake", n, (21 - trm) * dv * (pre + dis + ROW_CLKS));
    snd(0, 8'hD3);
    host.idle();
    rst_n = 1'b0;
    rst_mdl();
    #1;
    cmp();
    @(negedge ref_clk);
    rst_n = 1'b1;
    snd(0, 8'hAF);
    host.idle();
    complete_run();
  end
endmodule
